/* File: rtl/cprb_pattern_gen.sv */
// output test pattern generator with long and short pseudorandom sequences
`timescale 1ns/1ps
module cprb_pattern_gen
    import cprb_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    input  wire logic        i_adv,
    input  wire logic        i_clear,
    input  wire logic [3:0]  i_mode,
    input  wire logic        i_rst_long,
    input  wire logic        i_rst_short,
    input  wire logic [13:0] i_user_pattern,
    output logic      [13:0] o_pattern
);
    logic [22:0] long_q;
    logic [8:0]  short_q;
    logic [13:0] step_q;
    logic        phase_q;

    // long sequence, x^23 + x^18 + 1
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            long_q <= LONG_SEED;
        end else if (i_clear || i_rst_long) begin
            long_q <= LONG_SEED;
        end else if (i_adv) begin
            long_q <= {long_q[21:0], long_q[22] ^ long_q[17]};
        end
    end

    // short sequence, x^9 + x^5 + 1
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            short_q <= SHORT_SEED;
        end else if (i_clear || i_rst_short) begin
            short_q <= SHORT_SEED;
        end else if (i_adv) begin
            short_q <= {short_q[7:0], short_q[8] ^ short_q[4]};
        end
    end

    // sample counter and toggle phase
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            step_q  <= 14'h0000;
            phase_q <= 1'b0;
        end else if (i_clear) begin
            step_q  <= 14'h0000;
            phase_q <= 1'b0;
        end else if (i_adv) begin
            step_q  <= step_q + 14'h0001;
            phase_q <= ~phase_q;
        end
    end

    // pattern select
    always_comb begin
        unique case (i_mode)
            TP_MIDSCALE:    o_pattern = PAT_MIDSCALE;
            TP_POS_FS:      o_pattern = PAT_POS_FULL_SCALE;
            TP_NEG_FS:      o_pattern = PAT_NEG_FULL_SCALE;
            TP_CHECKER:     o_pattern = phase_q ? ~PAT_CHECKER : PAT_CHECKER;
            TP_LONG_PN:     o_pattern = long_q[13:0];
            TP_SHORT_PN:    o_pattern = {short_q[4:0], short_q};
            TP_WORD_TOGGLE: o_pattern = phase_q ? PAT_POS_FULL_SCALE : PAT_NEG_FULL_SCALE;
            TP_USER:        o_pattern = i_user_pattern;
            TP_BIT_TOGGLE:  o_pattern = {13'h0000, phase_q};
            TP_SYNC:        o_pattern = (step_q[3:0] == 4'h0) ? PAT_POS_FULL_SCALE
                                                              : PAT_NEG_FULL_SCALE;
            TP_ONE_HIGH:    o_pattern = 14'h0001 << step_q[3:0];
            TP_MIXED:       o_pattern = step_q;
            default:        o_pattern = PAT_MIDSCALE;
        endcase
    end
endmodule

/* File: rtl/cprb_pkg.sv */
// constants and types for the converter program register bank
package cprb_pkg;
    localparam int unsigned DATA_W = 14;
    // register offsets
    localparam logic [7:0] ADDR_OPERATING_MODES  = 8'h08;
    localparam logic [7:0] ADDR_CLOCK_DIVIDE     = 8'h0B;
    localparam logic [7:0] ADDR_TEST_PATTERN     = 8'h0D;
    localparam logic [7:0] ADDR_SELF_CHECK       = 8'h0E;
    localparam logic [7:0] ADDR_OFFSET_TRIM      = 8'h10;
    localparam logic [7:0] ADDR_SHADOW_UPDATE    = 8'hFF;
    // reset values
    localparam logic [7:0] RST_REG               = 8'h00;
    // writable bit masks, open bits read zero
    localparam logic [7:0] MASK_OPERATING_MODES  = 8'hE3;
    localparam logic [7:0] MASK_CLOCK_DIVIDE     = 8'h07;
    localparam logic [7:0] MASK_TEST_PATTERN     = 8'hFF;
    localparam logic [7:0] MASK_SELF_CHECK       = 8'h05;
    localparam logic [7:0] MASK_OFFSET_TRIM      = 8'hFF;
    localparam logic [7:0] CMD_SHADOW_UPDATE     = 8'h01;
    // field positions
    localparam int unsigned POS_EXT_PIN_EN       = 7;
    localparam int unsigned POS_EXT_FUNC         = 5;
    localparam int unsigned POS_RST_LONG         = 5;
    localparam int unsigned POS_RST_SHORT        = 4;
    localparam int unsigned POS_SELF_INIT        = 2;
    localparam int unsigned POS_SELF_START       = 0;
    // pattern constants, offset binary
    localparam logic [13:0] PAT_MIDSCALE         = 14'h2000;
    localparam logic [13:0] PAT_POS_FULL_SCALE   = 14'h3FFF;
    localparam logic [13:0] PAT_NEG_FULL_SCALE   = 14'h0000;
    localparam logic [13:0] PAT_CHECKER          = 14'h2AAA;
    localparam logic [22:0] LONG_SEED            = 23'h7FFFFF;
    localparam logic [8:0]  SHORT_SEED           = 9'h1FF;

    typedef enum logic [1:0] {
        CPRB_RUN        = 2'h0,
        CPRB_POWER_DOWN = 2'h1,
        CPRB_STANDBY    = 2'h2,
        CPRB_DIG_RESET  = 2'h3
    } cprb_mode_type;

    typedef enum logic [3:0] {
        TP_OFF = 4'h0, TP_MIDSCALE = 4'h1, TP_POS_FS = 4'h2, TP_NEG_FS = 4'h3,
        TP_CHECKER = 4'h4, TP_LONG_PN = 4'h5, TP_SHORT_PN = 4'h6,
        TP_WORD_TOGGLE = 4'h7, TP_USER = 4'h8, TP_BIT_TOGGLE = 4'h9,
        TP_SYNC = 4'hA, TP_ONE_HIGH = 4'hB, TP_MIXED = 4'hC
    } cprb_test_type;
endpackage

/* File: rtl/cprb_register_bank.sv */
// converter program register bank with shadowed program registers
`timescale 1ns/1ps
module cprb_register_bank
    import cprb_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_mode_pin,
    input  wire logic [13:0] i_sample,
    input  wire logic [13:0] i_user_pattern,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_power_down,
    output logic             o_standby,
    output logic             o_digital_reset,
    output logic             o_output_disable,
    output logic             o_sample_en,
    output logic      [13:0] o_data,
    output logic             o_self_check_start,
    output logic             o_self_check_init
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  modes_sh_q, div_sh_q, test_sh_q, self_sh_q, trim_sh_q;
    logic [7:0]  modes_q, div_q, test_q, self_q, trim_q;
    logic        transfer_q;
    logic [2:0]  div_cnt_q;
    logic [13:0] pattern;
    logic        dig_reset;
    logic [14:0] trimmed;

    // mask of writable bits for an address, zero when unmapped
    function automatic logic [7:0] cprb_mask(input logic [7:0] addr);
        unique case (addr)
            ADDR_OPERATING_MODES: cprb_mask = MASK_OPERATING_MODES;
            ADDR_CLOCK_DIVIDE:    cprb_mask = MASK_CLOCK_DIVIDE;
            ADDR_TEST_PATTERN:    cprb_mask = MASK_TEST_PATTERN;
            ADDR_SELF_CHECK:      cprb_mask = MASK_SELF_CHECK;
            ADDR_OFFSET_TRIM:     cprb_mask = MASK_OFFSET_TRIM;
            ADDR_SHADOW_UPDATE:   cprb_mask = CMD_SHADOW_UPDATE;
            default:              cprb_mask = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // master copies written by the serial host
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            modes_sh_q <= RST_REG;
            div_sh_q   <= RST_REG;
            test_sh_q  <= RST_REG;
            self_sh_q  <= RST_REG;
            trim_sh_q  <= RST_REG;
        end else if (i_reg_wr) begin
            // open bits dropped on write
            unique case (i_reg_addr)
                ADDR_OPERATING_MODES: modes_sh_q <= i_reg_wdata & MASK_OPERATING_MODES;
                ADDR_CLOCK_DIVIDE:    div_sh_q   <= i_reg_wdata & MASK_CLOCK_DIVIDE;
                ADDR_TEST_PATTERN:    test_sh_q  <= i_reg_wdata & MASK_TEST_PATTERN;
                ADDR_SELF_CHECK:      self_sh_q  <= i_reg_wdata & MASK_SELF_CHECK;
                ADDR_OFFSET_TRIM:     trim_sh_q  <= i_reg_wdata & MASK_OFFSET_TRIM;
                default:              ;
            endcase
        end
    end

    // transfer bit, set by 0x01 write, clears itself next cycle
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            transfer_q <= 1'b0;
        end else begin
            transfer_q <= i_reg_wr && (i_reg_addr == ADDR_SHADOW_UPDATE)
                          && i_reg_wdata[0];
        end
    end

    // active copies loaded all at once on transfer
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            modes_q <= RST_REG;
            div_q   <= RST_REG;
            test_q  <= RST_REG;
            self_q  <= RST_REG;
            trim_q  <= RST_REG;
        end else if (transfer_q) begin
            modes_q <= modes_sh_q;
            div_q   <= div_sh_q;
            test_q  <= test_sh_q;
            self_q  <= self_sh_q;
            trim_q  <= trim_sh_q;
        end
    end

    // registered read port, unmapped reads zero
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                ADDR_OPERATING_MODES: o_reg_rdata <= modes_sh_q;
                ADDR_CLOCK_DIVIDE:    o_reg_rdata <= div_sh_q;
                ADDR_TEST_PATTERN:    o_reg_rdata <= test_sh_q;
                ADDR_SELF_CHECK:      o_reg_rdata <= self_sh_q;
                ADDR_OFFSET_TRIM:     o_reg_rdata <= trim_sh_q;
                ADDR_SHADOW_UPDATE:   o_reg_rdata <= {7'h00, transfer_q};
                default:              o_reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // chip state from mode field and external pin
    assign dig_reset = (modes_q[1:0] == CPRB_DIG_RESET);

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_power_down     <= 1'b0;
            o_standby        <= 1'b0;
            o_digital_reset  <= 1'b0;
            o_output_disable <= 1'b0;
        end else if (modes_q[POS_EXT_PIN_EN] && i_mode_pin) begin
            // pin forces the neighbouring field's state
            o_power_down     <= modes_q[6:5] == 2'h0;
            o_standby        <= modes_q[6:5] == 2'h1;
            o_digital_reset  <= 1'b0;
            o_output_disable <= modes_q[6:5] == 2'h2;
        end else begin
            o_power_down     <= modes_q[1:0] == CPRB_POWER_DOWN;
            o_standby        <= modes_q[1:0] == CPRB_STANDBY;
            o_digital_reset  <= dig_reset;
            o_output_disable <= 1'b0;
        end
    end

    // input clock divider, one pulse every field+1 cycles
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_cnt_q   <= 3'h0;
            o_sample_en <= 1'b0;
        end else if (dig_reset) begin
            div_cnt_q   <= 3'h0;
            o_sample_en <= 1'b0;
        end else if (div_cnt_q >= div_q[2:0]) begin
            div_cnt_q   <= 3'h0;
            o_sample_en <= 1'b1;
        end else begin
            div_cnt_q   <= div_cnt_q + 3'h1;
            o_sample_en <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // test patterns
    cprb_pattern_gen u_pattern (
        .i_clock        (i_clock),
        .i_rst_b        (i_rst_b),
        .i_adv          (o_sample_en),
        .i_clear        (dig_reset),
        .i_mode         (test_q[3:0]),
        .i_rst_long     (test_q[POS_RST_LONG]),
        .i_rst_short    (test_q[POS_RST_SHORT]),
        .i_user_pattern (i_user_pattern),
        .o_pattern      (pattern)
    );

    // offset trim, sign-extended and saturated
    assign trimmed = {1'b0, i_sample} + {{7{trim_q[7]}}, trim_q};

    // output data, test pattern replaces samples
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_data <= 14'h0000;
        end else if (dig_reset) begin
            o_data <= 14'h0000;
        end else if (o_sample_en) begin
            if (test_q[3:0] != TP_OFF) begin
                o_data <= pattern;
            end else if (trim_q[7] && trimmed[14]) begin
                o_data <= PAT_NEG_FULL_SCALE;
            end else if (!trim_q[7] && trimmed[14]) begin
                o_data <= PAT_POS_FULL_SCALE;
            end else begin
                o_data <= trimmed[13:0];
            end
        end
    end

    // self-check pulses on transfer
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_self_check_start <= 1'b0;
            o_self_check_init  <= 1'b0;
        end else begin
            o_self_check_start <= transfer_q && self_sh_q[POS_SELF_START];
            o_self_check_init  <= transfer_q && self_sh_q[POS_SELF_INIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    a_transfer_autoclr: assert property (transfer_q |=> !transfer_q)
        else $error("transfer bit did not clear");
    a_transfer_copy: assert property (transfer_q |=> modes_q == $past(modes_sh_q)
        && trim_q == $past(trim_sh_q))
        else $error("active copy not loaded on transfer");
    a_shadow_holds: assert property (!transfer_q |=> $stable(test_q) && $stable(div_q))
        else $error("active register changed without transfer");
    a_mode_decode: assert property (!(modes_q[POS_EXT_PIN_EN] && i_mode_pin)
        && modes_q[1:0] == CPRB_POWER_DOWN |=> o_power_down && !o_standby)
        else $error("power-down not decoded");
    a_ext_pin: assert property (modes_q[7] && i_mode_pin && modes_q[6:5] == 2'h1
        |=> o_standby && !o_digital_reset)
        else $error("mode pin did not force standby");
    a_div_spacing: assert property (o_sample_en && div_q[2:0] == 3'h1 && !dig_reset
        && !transfer_q && $stable(div_q) |=> !o_sample_en ##1 o_sample_en)
        else $error("divide-by-2 spacing wrong");
    a_test_mux: assert property (o_sample_en && test_q[3:0] == TP_POS_FS && !dig_reset
        |=> o_data == PAT_POS_FULL_SCALE)
        else $error("test pattern not on outputs");
    a_offset_trim: assert property (o_sample_en && test_q[3:0] == TP_OFF && !dig_reset
        && !trimmed[14] |=> o_data == $past(trimmed[13:0]))
        else $error("offset trim not applied");
    a_self_start: assert property (transfer_q && self_sh_q[0] |=> o_self_check_start)
        else $error("self-check start missing");
    a_open_zero: assert property (i_reg_rd && i_reg_addr == ADDR_CLOCK_DIVIDE
        |=> o_reg_rdata[7:3] == 5'h00)
        else $error("open bits read nonzero");

    c_transfer: cover property (transfer_q ##1 o_self_check_start);
    c_long_pn: cover property (o_sample_en && test_q[3:0] == TP_LONG_PN);
    c_ext_pin: cover property (modes_q[7] && i_mode_pin);
    c_div4: cover property (o_sample_en && div_q[2:0] == 3'h3);
endmodule

/* File: test/cprb_host_model.sv */
// serial host model that programs the converter register bank
`timescale 1ns/1ps
module cprb_host_model
    import cprb_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata
);
    // writable bits of each program register, zero for the transfer command and open ones
    function automatic logic [7:0] open_mask(input logic [7:0] a);
        case (a)
            ADDR_OPERATING_MODES: return MASK_OPERATING_MODES;
            ADDR_CLOCK_DIVIDE:    return MASK_CLOCK_DIVIDE;
            ADDR_TEST_PATTERN:    return MASK_TEST_PATTERN;
            ADDR_SELF_CHECK:      return MASK_SELF_CHECK;
            ADDR_OFFSET_TRIM:     return MASK_OFFSET_TRIM;
            default:              return 8'h00;
        endcase
    endfunction
    // idle bus after time zero
    initial begin
        o_wr    = 1'h0;
        o_rd    = 1'h0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end
    // one write, open bits zeroed unless a raw write is asked for
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw);
        @(negedge i_clock);
        o_wr    = 1'h1;
        o_addr  = a;
        o_wdata = raw ? d : (d & open_mask(a));
        @(negedge i_clock);
        o_wr    = 1'h0;
        o_wdata = ~o_wdata; // released bus shows no stale value
    endtask
    // one read, data taken one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clock);
        o_rd   = 1'h1;
        o_addr = a;
        @(negedge i_clock);
        o_rd   = 1'h0;
        o_addr = ~a;
        d      = i_rdata;
    endtask
    // transfer command, then wait until active copies and mode outputs land
    task automatic xfer();
        wr(ADDR_SHADOW_UPDATE, CMD_SHADOW_UPDATE, 1'h1);
        repeat (3) @(negedge i_clock);
    endtask
endmodule

/* File: test/cprb_register_bank_tb_top.sv */
// self-checking bench for the converter program register bank
`timescale 1ns/1ps
module cprb_register_bank_tb_top;
    import cprb_pkg::*;
    logic i_clock = 1'h0, i_rst_b = 1'h0, i_mode_pin = 1'h0;
    logic [13:0] i_sample = 14'h0000, i_user_pattern = 14'h0000, w1, w2;
    logic i_reg_wr, i_reg_rd, o_power_down, o_standby, o_digital_reset, o_output_disable;
    logic o_sample_en, o_self_check_start, o_self_check_init;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d;
    logic [13:0] o_data;
    int seed = 70154, miscompares = 0, cmp_count = 0, cycles = 0, starts = 0, inits = 0;
    int shadow [256], act [256], n, t;
    logic [7:0] regs [6] = '{8'h08, 8'h0B, 8'h0D, 8'h0E, 8'h10, 8'hFF};
    logic [7:0] codes [5] = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h0D};
    logic [7:0] pairs [3] = '{8'h04, 8'h07, 8'h09};
    logic [13:0] pexp [3] = '{14'h3FFF, 14'h3FFF, 14'h0001};
    logic [7:0] divs [4];

    cprb_register_bank dut_u (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_mode_pin(i_mode_pin), .i_sample(i_sample), .i_user_pattern(i_user_pattern),
        .o_reg_rdata(o_reg_rdata), .o_power_down(o_power_down), .o_standby(o_standby),
        .o_digital_reset(o_digital_reset), .o_output_disable(o_output_disable),
        .o_sample_en(o_sample_en), .o_data(o_data),
        .o_self_check_start(o_self_check_start), .o_self_check_init(o_self_check_init));
    cprb_host_model host_u (.i_clock(i_clock), .i_rdata(o_reg_rdata), .o_wr(i_reg_wr),
        .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, pulse counters and hang limit
    always #2 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        starts += (o_self_check_start === 1'h1);
        inits  += (o_self_check_init === 1'h1);
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // comparison, verdict and model helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic set_reg(input logic [7:0] a, input logic [7:0] v, input bit raw);
        host_u.wr(a, v, raw);
        shadow[a] = v & host_u.open_mask(a);
    endtask
    task automatic xfer();
        host_u.xfer();
        act = shadow;
    endtask
    // word produced for the next sample pulse, bounded wait
    // a pulse already showing is used, so two calls give adjacent words
    task automatic get_word(output logic [13:0] w);
        n = 0;
        while (o_sample_en !== 1'h1 && n < 20) begin
            @(negedge i_clock);
            n++;
        end
        @(negedge i_clock);
        w = o_data;
    endtask
    function automatic logic [13:0] trimmed(input int s, input int tr);
        int r;
        r = s + ((tr > 127) ? tr - 256 : tr);
        return (r < 0) ? 14'h0000 : (r > 16383) ? 14'h3FFF : r[13:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        foreach (shadow[i]) shadow[i] = 0;
        act = shadow;
        repeat (4) @(negedge i_clock);
        i_rst_b = 1'h1;
        foreach (regs[i]) begin
            host_u.rd(regs[i], d);
            chk(d, 8'h00);
        end
        host_u.rd(8'h09, d);
        chk(d, 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            set_reg(regs[i], $random(seed), 1'h1);
            host_u.rd(regs[i], d);
            chk(d, shadow[regs[i]]);
        end
        $display("test open bits done");
        foreach (regs[i]) if (i < 5) set_reg(regs[i], 8'h00, 1'h0);
        set_reg(ADDR_TEST_PATTERN, 8'h02, 1'h0);
        i_sample = $random(seed);
        get_word(w1);
        chk(w1, i_sample);
        xfer();
        get_word(w1);
        chk(w1, 14'h3FFF);
        host_u.rd(ADDR_SHADOW_UPDATE, d);
        chk(d, 8'h00);
        $display("test transfer done");
        i_user_pattern = $random(seed);
        foreach (codes[i]) begin
            set_reg(ADDR_TEST_PATTERN, codes[i], 1'h0);
            xfer();
            get_word(w1);
            chk(w1, (i == 3) ? i_user_pattern : (i == 1) ? 14'h3FFF :
                (i == 2) ? 14'h0000 : 14'h2000);
        end
        foreach (pairs[i]) begin
            set_reg(ADDR_TEST_PATTERN, pairs[i], 1'h0);
            xfer();
            get_word(w1);
            get_word(w2);
            chk(w1 ^ w2, pexp[i]);
        end
        set_reg(ADDR_TEST_PATTERN, 8'h25, 1'h0);
        xfer();
        get_word(w1);
        get_word(w2);
        chk(w1, 14'h3FFF);
        chk(w2, 14'h3FFF);
        set_reg(ADDR_TEST_PATTERN, 8'h16, 1'h0);
        xfer();
        get_word(w1);
        get_word(w2);
        chk(w1, w2);
        // running long and short sequences give two different adjacent words
        for (int c = 5; c < 7; c++) begin
            set_reg(ADDR_TEST_PATTERN, c, 1'h0);
            xfer();
            get_word(w1);
            get_word(w2);
            chk(w1 != w2, 1'h1);
        end
        // sync, one-high and mixed codes over sixteen adjacent words
        for (int c = 10; c < 13; c++) begin
            set_reg(ADDR_TEST_PATTERN, c, 1'h0);
            xfer();
            get_word(w2);
            t = 0;
            for (int k = 0; k < 16; k++) begin
                w1 = w2;
                get_word(w2);
                t += (c == 10) ? (w2 == 14'h3FFF) : (c == 11) ? (w2 != 14'h0000)
                                                              : (w2 == w1 + 14'h0001);
            end
            chk(t, (c == 10) ? 1 : (c == 11) ? 14 : 16);
        end
        $display("test patterns done");
        set_reg(ADDR_TEST_PATTERN, 8'h00, 1'h0);
        for (int i = 0; i < 10; i++) begin
            t = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : $random(seed) & 8'hFF;
            i_sample = (i == 0) ? 14'h3FF0 : (i == 1) ? 14'h0010 : $random(seed);
            set_reg(ADDR_OFFSET_TRIM, t, 1'h0);
            xfer();
            get_word(w1);
            chk(w1, trimmed(i_sample, act[ADDR_OFFSET_TRIM]));
        end
        $display("test offset trim done");
        divs = '{8'h00, 8'h01, 8'h03, $random(seed) & 8'h07};
        foreach (divs[i]) begin
            set_reg(ADDR_CLOCK_DIVIDE, divs[i], 1'h0);
            xfer();
            get_word(w1);
            // line up on a pulse, then count to the next one
            while (o_sample_en !== 1'h1) @(negedge i_clock);
            n = 0;
            do begin
                @(negedge i_clock);
                n++;
            end while (o_sample_en !== 1'h1 && n < 20);
            chk(n, divs[i] + 1);
        end
        set_reg(ADDR_CLOCK_DIVIDE, 8'h00, 1'h0);
        $display("test divider done");
        for (int m = 3; m >= 0; m--) begin
            set_reg(ADDR_OPERATING_MODES, m, 1'h0);
            xfer();
            chk({o_power_down, o_standby, o_digital_reset}, 3'h4 >> (m - 1));
            if (m == 3) chk({o_sample_en, o_data}, 15'h0000);
        end
        for (int f = 0; f < 3; f++) begin
            set_reg(ADDR_OPERATING_MODES, 8'h80 | (f << POS_EXT_FUNC), 1'h0);
            xfer();
            i_mode_pin = 1'h1;
            repeat (2) @(negedge i_clock);
            chk({o_power_down, o_standby, o_output_disable}, 3'h4 >> f);
            i_mode_pin = 1'h0;
            repeat (2) @(negedge i_clock);
            chk({o_power_down, o_standby, o_output_disable}, 3'h0);
        end
        $display("test modes done");
        starts = 0;
        inits = 0;
        set_reg(ADDR_SELF_CHECK, 8'h05, 1'h0);
        xfer();
        chk({starts[3:0], inits[3:0]}, 8'h11);
        set_reg(ADDR_SELF_CHECK, 8'h00, 1'h0);
        xfer();
        chk({starts[3:0], inits[3:0]}, 8'h11);
        $display("test self check done");
        report_and_stop();
    end
endmodule
